// file: verilog/i2c_master_restart_and_transmit.sv
// two-wire bus master: repeated start generation and byte transmission
// assumes open-drain pins resolved outside; all pin inputs are asynchronous
`timescale 1ns/1ps

// --------------------------------------------------------------------------
// byte buffer between the writer and the shifter
// --------------------------------------------------------------------------
module i2c_byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clock,    // system clock
    input  wire logic             rst,      // synchronous reset
    input  wire logic [WIDTH-1:0] inData,   // data to store
    input  wire logic             inValid,  // writer offers data
    output logic                  inReady,  // room for one more
    output logic      [WIDTH-1:0] outData,  // oldest entry
    output logic                  outValid, // an entry is present
    input  wire logic             outReady  // reader takes the entry
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_q;
    logic [AW-1:0]    rdPtr_q;
    logic [AW:0]      count_q;
    wire              doPush = inValid && inReady;
    wire              doPop  = outValid && outReady;

    assign inReady  = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData  = mem[rdPtr_q];

    always_ff @(posedge clock) begin
        if (doPush) begin
            mem[wrPtr_q] <= inData;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (doPush) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
            count_q <= count_q + (AW+1)'(doPush) - (AW+1)'(doPop);
        end
    end
endmodule

// --------------------------------------------------------------------------
// master sequencer
// --------------------------------------------------------------------------
module i2c_master_restart_and_transmit (
    input  wire logic                                   clock,            // 10 MHz system clock
    input  wire logic                                   rst,              // synchronous reset
    input  wire logic [i2c_master_pkg::BAUD_WIDTH-1:0]  baudReload,       // generator reload value
    input  wire logic                                   repeatedStartSet, // pulse: request repeated start
    input  wire logic [i2c_master_pkg::BYTE_WIDTH-1:0]  bufferData,       // byte for the bus
    input  wire logic                                   bufferValid,      // byte offered
    output logic                                        bufferReady,      // byte accepted
    input  wire logic                                   irqClear,         // pulse: clear interrupt flag
    input  wire logic                                   startClear,       // pulse: clear start-detected
    input  wire logic                                   collisionClear,   // pulse: clear collision flag
    output i2c_master_pkg::status_type                  status,           // status bits
    input  wire logic                                   sclIn,            // clock pin level
    output logic                                        sclOut,           // clock pin output value
    output logic                                        sclOeN,           // low while pulling clock
    input  wire logic                                   sdaIn,            // data pin level
    output logic                                        sdaOut,           // data pin output value
    output logic                                        sdaOeN            // low while pulling data
);
    typedef i2c_master_pkg::state_type state_type;

    // ----------------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------------
    logic [1:0] sclSync_q;
    logic [1:0] sdaSync_q;
    logic       sclPrev_q;
    logic       sdaPrev_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            sclSync_q <= 2'h3;
            sdaSync_q <= 2'h3;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            sclSync_q <= {sclSync_q[0], sclIn};
            sdaSync_q <= {sdaSync_q[0], sdaIn};
            sclPrev_q <= sclSync_q[1];
            sdaPrev_q <= sdaSync_q[1];
        end
    end

    wire sclHigh = sclSync_q[1];
    wire sdaHigh = sdaSync_q[1];
    wire sclRose = sclHigh && !sclPrev_q;
    wire sclFell = !sclHigh && sclPrev_q;
    wire startSeen = sclHigh && sclPrev_q && !sdaHigh && sdaPrev_q;

    // ----------------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------------
    logic [i2c_master_pkg::BYTE_WIDTH-1:0] fifoData;
    logic                                  fifoValid;
    logic                                  fifoPop;

    i2c_byte_fifo #(
        .WIDTH (i2c_master_pkg::BYTE_WIDTH),
        .DEPTH (i2c_master_pkg::FIFO_DEPTH)
    ) byteFifo (
        .clock    (clock),
        .rst      (rst),
        .inData   (bufferData),
        .inValid  (bufferValid),
        .inReady  (bufferReady),
        .outData  (fifoData),
        .outValid (fifoValid),
        .outReady (fifoPop)
    );

    // ----------------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------------
    state_type                             state_q;
    state_type                             state_d;
    logic [i2c_master_pkg::BAUD_WIDTH-1:0] baudCnt_q;
    logic [i2c_master_pkg::BYTE_WIDTH-1:0] shift_q;
    logic [2:0]                            bitIdx_q;
    logic                                  sclLow_q;
    logic                                  sdaLow_q;
    logic                                  rsReq_q;
    logic                                  bufFull_q;
    logic                                  ackResult_q;
    logic                                  startFlag_q;
    logic                                  irqFlag_q;
    logic                                  collFlag_q;

    wire baudTick = (baudCnt_q == i2c_master_pkg::BAUD_ZERO);
    wire isIdle   = (state_q == i2c_master_pkg::ST_IDLE);

    wire rsAccept = repeatedStartSet && isIdle;
    // rs wins over a waiting byte
    assign fifoPop = isIdle && !rsAccept && !rsReq_q && fifoValid;

    wire collRise = (state_q == i2c_master_pkg::ST_RS_SCLREL) && sclRose && !sdaHigh;
    wire collFall = ((state_q == i2c_master_pkg::ST_RS_HIGH) || (state_q == i2c_master_pkg::ST_RS_SDALOW))
                    && sclFell;
    wire collision = collRise || collFall;

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        if (collision) begin
            state_d = i2c_master_pkg::ST_IDLE;
        end else begin
            case (state_q)
                i2c_master_pkg::ST_IDLE: begin
                    if (rsAccept) begin
                        state_d = i2c_master_pkg::ST_RS_SCLLOW;
                    end else if (fifoPop) begin
                        state_d = i2c_master_pkg::ST_TX_LOW;
                    end
                end
                i2c_master_pkg::ST_RS_SCLLOW: begin
                    if (!sclHigh) begin
                        state_d = i2c_master_pkg::ST_RS_SDAREL;
                    end
                end
                i2c_master_pkg::ST_RS_SDAREL: begin
                    // data must read high before the clock is let go
                    if (baudTick && sdaHigh) begin
                        state_d = i2c_master_pkg::ST_RS_SCLREL;
                    end
                end
                i2c_master_pkg::ST_RS_SCLREL: begin
                    if (sclHigh) begin
                        state_d = i2c_master_pkg::ST_RS_HIGH;
                    end
                end
                i2c_master_pkg::ST_RS_HIGH: begin
                    if (baudTick) begin
                        state_d = i2c_master_pkg::ST_RS_SDALOW;
                    end
                end
                i2c_master_pkg::ST_RS_SDALOW: begin
                    if (baudTick) begin
                        state_d = i2c_master_pkg::ST_IDLE;
                    end
                end
                i2c_master_pkg::ST_TX_LOW: begin
                    if (baudTick) begin
                        state_d = i2c_master_pkg::ST_TX_RISE;
                    end
                end
                i2c_master_pkg::ST_TX_RISE: begin
                    // a slave may stretch the clock here
                    if (sclHigh) begin
                        state_d = i2c_master_pkg::ST_TX_HIGH;
                    end
                end
                i2c_master_pkg::ST_TX_HIGH: begin
                    if (baudTick) begin
                        state_d = (bitIdx_q == i2c_master_pkg::LAST_BIT_INDEX) ?
                                  i2c_master_pkg::ST_ACK_LOW : i2c_master_pkg::ST_TX_LOW;
                    end
                end
                i2c_master_pkg::ST_ACK_LOW: begin
                    if (baudTick) begin
                        state_d = i2c_master_pkg::ST_ACK_RISE;
                    end
                end
                i2c_master_pkg::ST_ACK_RISE: begin
                    if (sclHigh) begin
                        state_d = i2c_master_pkg::ST_ACK_HIGH;
                    end
                end
                i2c_master_pkg::ST_ACK_HIGH: begin
                    if (baudTick) begin
                        state_d = i2c_master_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_d = i2c_master_pkg::ST_IDLE;
                end
            endcase
        end
    end

    wire stateChange = (state_d != state_q);
    wire rsDone  = (state_q == i2c_master_pkg::ST_RS_SDALOW) && baudTick && !collision;
    wire ackDone = (state_q == i2c_master_pkg::ST_ACK_HIGH) && baudTick;
    wire ackTake = (state_q == i2c_master_pkg::ST_ACK_RISE) && sclHigh;
    wire bitFall = (state_q == i2c_master_pkg::ST_TX_HIGH) && baudTick;

    // ----------------------------------------------------------------------
    // sequencer and baud generator
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q   <= i2c_master_pkg::ST_IDLE;
            baudCnt_q <= i2c_master_pkg::BAUD_ZERO;
        end else begin
            state_q <= state_d;
            if (stateChange && state_d != i2c_master_pkg::ST_IDLE) begin
                baudCnt_q <= baudReload;
            end else if (!baudTick) begin
                baudCnt_q <= baudCnt_q - 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------------
    // shifter
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            shift_q  <= '0;
            bitIdx_q <= i2c_master_pkg::FIRST_BIT_INDEX;
        end else if (fifoPop) begin
            shift_q  <= fifoData;
            bitIdx_q <= i2c_master_pkg::FIRST_BIT_INDEX;
        end else if (bitFall) begin
            shift_q  <= {shift_q[i2c_master_pkg::BYTE_WIDTH-2:0], 1'b0};
            bitIdx_q <= bitIdx_q + 1'b1;
        end
    end

    // ----------------------------------------------------------------------
    // line drivers
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst || collision) begin
            sclLow_q <= i2c_master_pkg::LINE_RELEASED;
            sdaLow_q <= i2c_master_pkg::LINE_RELEASED;
        end else begin
            case (state_d)
                i2c_master_pkg::ST_RS_SCLLOW: begin
                    sclLow_q <= 1'b1;
                end
                i2c_master_pkg::ST_RS_SDAREL: begin
                    sclLow_q <= 1'b1;
                    sdaLow_q <= 1'b0;
                end
                i2c_master_pkg::ST_RS_SCLREL, i2c_master_pkg::ST_RS_HIGH: begin
                    sclLow_q <= 1'b0;
                    sdaLow_q <= 1'b0;
                end
                i2c_master_pkg::ST_RS_SDALOW: begin
                    sdaLow_q <= 1'b1;
                end
                // bit picked on entry only; the shifter has moved on by the next cycle
                i2c_master_pkg::ST_TX_LOW: begin
                    sclLow_q <= 1'b1;
                    sdaLow_q <= stateChange ? !(fifoPop ? fifoData[i2c_master_pkg::BYTE_WIDTH-1]
                                                        : shift_q[i2c_master_pkg::BYTE_WIDTH-2]) : sdaLow_q;
                end
                i2c_master_pkg::ST_TX_RISE, i2c_master_pkg::ST_TX_HIGH,
                i2c_master_pkg::ST_ACK_RISE, i2c_master_pkg::ST_ACK_HIGH: begin
                    sclLow_q <= 1'b0;
                end
                i2c_master_pkg::ST_ACK_LOW: begin
                    sclLow_q <= 1'b1;
                    sdaLow_q <= 1'b0;
                end
                default: begin
                    if (rsDone || ackDone) begin
                        sclLow_q <= 1'b1;
                    end
                end
            endcase
        end
    end

    // ----------------------------------------------------------------------
    // status flags; a set in the clearing cycle wins
    // ----------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            rsReq_q     <= 1'b0;
            bufFull_q   <= 1'b0;
            ackResult_q <= i2c_master_pkg::ACK_RESULT_RST;
            startFlag_q <= 1'b0;
            irqFlag_q   <= 1'b0;
            collFlag_q  <= 1'b0;
        end else begin
            if (rsAccept) begin
                rsReq_q <= 1'b1;
            end else if (rsDone || collision) begin
                rsReq_q <= 1'b0;
            end
            if (fifoPop) begin
                bufFull_q <= 1'b1;
            end else if (bitFall && bitIdx_q == i2c_master_pkg::LAST_BIT_INDEX) begin
                bufFull_q <= 1'b0;
            end else if (collision) begin
                bufFull_q <= 1'b0;
            end
            if (ackTake) begin
                ackResult_q <= sdaHigh;
            end
            if (startSeen) begin
                startFlag_q <= 1'b1;
            end else if (startClear) begin
                startFlag_q <= 1'b0;
            end
            if (rsDone || ackDone) begin
                irqFlag_q <= 1'b1;
            end else if (irqClear) begin
                irqFlag_q <= 1'b0;
            end
            if (collision) begin
                collFlag_q <= 1'b1;
            end else if (collisionClear) begin
                collFlag_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------------
    // outputs; pins are open drain so the driven value is always low
    // ----------------------------------------------------------------------
    assign sclOut = 1'b0;
    assign sdaOut = 1'b0;
    assign sclOeN = !sclLow_q;
    assign sdaOeN = !sdaLow_q;

    assign status.serialPortIrqFlag    = irqFlag_q;
    assign status.bufferFullFlag       = bufFull_q;
    assign status.acknowledgeResultBit = ackResult_q;
    assign status.startDetected        = startFlag_q;
    assign status.busCollision         = collFlag_q;
    assign status.repeatedStartRequest = rsReq_q;
endmodule

// file: verilog/i2c_master_pkg.sv
// package for the two-wire master: widths, state encoding, status carrier
// assumes one 10 MHz clock and a synchronous active-high reset everywhere
package i2c_master_pkg;

    // ----------------------------------------------------------------------
    // widths and depths
    // ----------------------------------------------------------------------
    localparam int unsigned BYTE_WIDTH  = 8;
    localparam int unsigned BAUD_WIDTH  = 8;
    localparam int unsigned FIFO_DEPTH  = 16;
    localparam int unsigned SYNC_STAGES = 2;

    // ----------------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------------
    localparam logic [2:0] LAST_BIT_INDEX  = 3'h7;
    localparam logic [2:0] FIRST_BIT_INDEX = 3'h0;
    localparam logic       LINE_RELEASED   = 1'b0;
    localparam logic       ACK_RESULT_RST  = 1'b0;
    localparam logic [BAUD_WIDTH-1:0] BAUD_ZERO = 8'h00;

    // ----------------------------------------------------------------------
    // master sequencer states, gray coded in the order listed
    // ----------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE      = 4'h0,
        ST_RS_SCLLOW = 4'h1,
        ST_RS_SDAREL = 4'h3,
        ST_RS_SCLREL = 4'h2,
        ST_RS_HIGH   = 4'h6,
        ST_RS_SDALOW = 4'h7,
        ST_TX_LOW    = 4'h5,
        ST_TX_RISE   = 4'h4,
        ST_TX_HIGH   = 4'hC,
        ST_ACK_LOW   = 4'hD,
        ST_ACK_RISE  = 4'hF,
        ST_ACK_HIGH  = 4'hE
    } state_type;

    // ----------------------------------------------------------------------
    // status carried out of the block together
    // ----------------------------------------------------------------------
    typedef struct packed {
        logic serialPortIrqFlag;
        logic bufferFullFlag;
        logic acknowledgeResultBit;
        logic startDetected;
        logic busCollision;
        logic repeatedStartRequest;
    } status_type;

endpackage

// file: tb/i2c_slave_model.sv
// slave stand-in: counts clock falls, acknowledges the ninth bit
// assumes resolved wire levels and the bench clock
`timescale 1ns/1ps
module i2c_slave_model (
    input  wire logic clock,   // bench clock
    input  wire logic rst,     // synchronous reset
    input  wire logic scl,     // resolved clock line
    input  wire logic sda,     // resolved data line
    input  wire logic ackOn,   // acknowledge when high
    output logic      sdaPullN // low while pulling data
);
    logic       sclPrev_q;
    logic       sdaPrev_q;
    logic [3:0] bitCnt_q;
    // ------------------------------------------------------------
    // bit counting
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        sclPrev_q <= scl;
        sdaPrev_q <= sda;
        if (rst || (scl && sclPrev_q && sdaPrev_q && !sda)) begin
            bitCnt_q <= 4'h0;
            sdaPullN <= 1'b1;
        end else if (sclPrev_q && !scl) begin
            bitCnt_q <= (bitCnt_q == 4'h9) ? 4'h1 : bitCnt_q + 4'h1;
            sdaPullN <= !(ackOn && bitCnt_q == 4'h8);
        end
    end
endmodule

// file: tb/i2c_master_checker.sv
// timing relations of the master pins and status bits
// assumes a generator reload of 2 or more
`timescale 1ns/1ps
module i2c_master_checker (
    input wire logic                  clock,            // system clock
    input wire logic                  rst,              // synchronous reset
    input wire logic                  repeatedStartSet, // request pulse
    input i2c_master_pkg::status_type status,           // status bits
    input wire logic                  sclOeN,           // clock pull, active low
    input wire logic                  sdaOeN            // data pull, active low
);
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_rs_take;
        $rose(status.repeatedStartRequest) |-> $past(repeatedStartSet) && !$past(status.bufferFullFlag);
    endproperty
    a_rs_take: assert property (p_rs_take) else $error("repeated start taken without request");
    property p_rs_pull; $rose(status.repeatedStartRequest) |-> !sclOeN; endproperty
    a_rs_pull: assert property (p_rs_pull) else $error("clock not pulled at request");
    property p_rs_end;
        $fell(status.repeatedStartRequest) && !status.busCollision |-> !sclOeN && !sdaOeN;
    endproperty
    a_rs_end: assert property (p_rs_end) else $error("lines wrong after repeated start");
    property p_irq; $rose(status.serialPortIrqFlag) |-> !sclOeN && !status.repeatedStartRequest; endproperty
    a_irq: assert property (p_irq) else $error("interrupt flag set too early");
    property p_tx_start; $rose(status.bufferFullFlag) |-> !sclOeN; endproperty
    a_tx_start: assert property (p_tx_start) else $error("byte start without clock low");
    property p_tx_low; $fell(sclOeN) |-> !sclOeN [*3]; endproperty
    a_tx_low: assert property (p_tx_low) else $error("clock low phase too short");
    property p_tx_stable;
        sclOeN && $past(sclOeN) && status.bufferFullFlag && $past(status.bufferFullFlag) |-> $stable(sdaOeN);
    endproperty
    a_tx_stable: assert property (p_tx_stable) else $error("data moved while clock high");
    property p_tx_eighth; $fell(status.bufferFullFlag) && !status.busCollision |-> sdaOeN && !sclOeN; endproperty
    a_tx_eighth: assert property (p_tx_eighth) else $error("data not released after eighth bit");
    property p_ack; $changed(status.acknowledgeResultBit) |-> sclOeN; endproperty
    a_ack: assert property (p_ack) else $error("ack result changed with clock low");
    property p_coll;
        $rose(status.busCollision) |-> sclOeN && sdaOeN && !status.repeatedStartRequest && !status.bufferFullFlag;
    endproperty
    a_coll: assert property (p_coll) else $error("collision left lines or sequence active");
    c_rs_done: cover property ($fell(status.repeatedStartRequest) && !status.busCollision);
    c_coll: cover property ($rose(status.busCollision));
    c_nack: cover property ($rose(status.acknowledgeResultBit));
endmodule

bind i2c_master_restart_and_transmit i2c_master_checker chk (.clock(clock), .rst(rst),
    .repeatedStartSet(repeatedStartSet), .status(status), .sclOeN(sclOeN), .sdaOeN(sdaOeN));

// file: tb/i2c_master_restart_and_transmit_tb.sv
// bench: repeated start, bytes with and without ack, buffer fill, collisions
// assumes the slave model and checker are compiled before this file
`timescale 1ns/1ps
module i2c_master_restart_and_transmit_tb;
    localparam int LIM = 5000;
    logic clock, rst, repeatedStartSet, bufferValid, bufferReady, irqClear, startClear, collisionClear;
    logic sclOeN, sdaOeN, sclOut, sdaOut, sclHoldN, sdaHoldN, sdaPullN, ackOn, sclPrev;
    logic [7:0] bufferData, rxByte;
    logic [7:0] rxQ[$];
    i2c_master_pkg::status_type status;
    int error_cnt = 0, n_tests = 0, rxBits = 0;
    wire scl = (sclOeN | sclOut) & sclHoldN;
    wire sda = (sdaOeN | sdaOut) & sdaPullN & sdaHoldN;
    i2c_master_restart_and_transmit DUT (.clock(clock), .rst(rst), .baudReload(8'h02),
        .repeatedStartSet(repeatedStartSet), .bufferData(bufferData), .bufferValid(bufferValid),
        .bufferReady(bufferReady), .irqClear(irqClear), .startClear(startClear),
        .collisionClear(collisionClear), .status(status), .sclIn(scl), .sclOut(sclOut), .sclOeN(sclOeN),
        .sdaIn(sda), .sdaOut(sdaOut), .sdaOeN(sdaOeN));
    i2c_slave_model SLAVE (.clock(clock), .rst(rst), .scl(scl), .sda(sda), .ackOn(ackOn), .sdaPullN(sdaPullN));
    // ------------------------------------------------------------
    // clock and wire monitor
    // ------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        sclPrev <= scl;
        if (!sclPrev && scl && status.bufferFullFlag) begin
            rxByte = {rxByte[6:0], sda};
            rxBits++;
            if (rxBits == 8) begin
                rxQ.push_back(rxByte);
                rxBits = 0;
            end
        end
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task conclude();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task limit(input int i);
        if (i >= LIM) begin
            chk("wait bound", 8'h00, 8'h01);
            conclude();
        end
    endtask
    task pulse_rs();
        repeatedStartSet = 1'b1;
        @(negedge clock);
        repeatedStartSet = 1'b0;
    endtask
    task clear_all();
        {irqClear, startClear, collisionClear} = 3'h7;
        @(negedge clock);
        {irqClear, startClear, collisionClear} = 3'h0;
        chk("flags cleared", 8'h00, {status.serialPortIrqFlag, status.startDetected, status.busCollision});
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task t_restart();
        int i, sdaLow;
        sdaLow = 0;
        pulse_rs();
        chk("rs request and pull", 8'h02, {status.repeatedStartRequest, sclOeN});
        for (i = 0; i < LIM && status.repeatedStartRequest === 1'b1; i++) begin
            if (sclOeN === 1'b1 && sdaOeN === 1'b0) sdaLow++;
            @(negedge clock);
        end
        limit(i);
        chk("data low tick", 8'h03, 8'(sdaLow));
        chk("end of restart", 8'h03, {sclOeN, sdaOeN, status.serialPortIrqFlag, status.startDetected});
        clear_all();
    endtask
    task t_byte(input logic [7:0] d, input logic ack);
        int i;
        {ackOn, bufferData, bufferValid} = {ack, d, 1'b1};
        @(negedge clock);
        bufferValid = 1'b0;
        for (i = 0; i < 8 && status.bufferFullFlag !== 1'b1; i++) @(negedge clock);
        chk("buffer full", 8'h01, status.bufferFullFlag);
        pulse_rs();
        chk("rs while busy", 8'h00, status.repeatedStartRequest);
        for (i = 0; i < LIM && status.serialPortIrqFlag !== 1'b1; i++) @(negedge clock);
        limit(i);
        chk("byte on wire", d, rxQ.pop_back());
        chk("ack result", {7'h00, !ack}, status.acknowledgeResultBit);
        chk("after ninth", 8'h00, {sclOeN, status.bufferFullFlag, status.repeatedStartRequest});
        clear_all();
    endtask
    task t_fifo();
        int i, n;
        // clock stretched by the far side so only the first byte leaves the buffer
        {sclHoldN, ackOn, bufferValid} = 3'h3;
        for (n = 0; n < 40 && bufferReady === 1'b1; n++) begin
            bufferData = 8'h10 + 8'(n);
            @(negedge clock);
        end
        bufferValid = 1'b0;
        chk("bytes accepted", 8'h11, 8'(n));
        sclHoldN = 1'b1;
        for (i = 0; i < LIM && rxQ.size() < 17; i++) @(negedge clock);
        limit(i);
        for (i = 0; i < 17; i++) chk("drained byte", 8'h10 + 8'(i), rxQ[i]);
        repeat (16) @(negedge clock);
        chk("buffer empty", 8'h01, bufferReady);
        clear_all();
    endtask
    task t_collide(input logic viaScl);
        int i;
        pulse_rs();
        for (i = 0; i < LIM && sclOeN !== 1'b1; i++) @(negedge clock);
        limit(i);
        // clock fall lands inside the both-high tick
        if (viaScl) repeat (2) @(negedge clock);
        if (viaScl) sclHoldN = 1'b0;
        else sdaHoldN = 1'b0;
        for (i = 0; i < 50 && status.busCollision !== 1'b1; i++) @(negedge clock);
        chk("collision flag", 8'h01, status.busCollision);
        chk("lines released", 8'h06, {sclOeN, sdaOeN, status.repeatedStartRequest});
        {sclHoldN, sdaHoldN} = 2'h3;
        clear_all();
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        {rst, repeatedStartSet, bufferValid, irqClear, startClear, collisionClear} = 6'h20;
        {sclHoldN, sdaHoldN, ackOn, bufferData} = {3'h7, 8'h00};
        repeat (4) @(negedge clock);
        rst = 1'b0;
        chk("reset state", 8'h03, {status, sclOeN, sdaOeN});
        t_restart();
        t_byte(8'hA5, 1'b1);
        t_byte(8'h3C, 1'b0);
        t_fifo();
        t_collide(1'b0);
        t_collide(1'b1);
        conclude();
    end
endmodule
